// ### pdr_cfg.svh
// Timing counts and reset values for the power-down and reset control block
`ifndef PDR_CFG_SVH
`define PDR_CFG_SVH
`define PDR_CLK_PERIOD_NS 8
`define PDR_SHORT_NS 60
`define PDR_LONG_NS 90
`define PDR_IFACE_UP_US 500
`define PDR_REF_UP_US 5500
// Least times round up to whole clock cycles
`define PDR_SHORT_CYC ((`PDR_SHORT_NS + `PDR_CLK_PERIOD_NS - 1) / `PDR_CLK_PERIOD_NS)
`define PDR_LONG_CYC ((`PDR_LONG_NS + `PDR_CLK_PERIOD_NS - 1) / `PDR_CLK_PERIOD_NS)
`define PDR_IFACE_UP_CYC ((`PDR_IFACE_UP_US * 1000 + `PDR_CLK_PERIOD_NS - 1) / `PDR_CLK_PERIOD_NS)
`define PDR_REF_UP_CYC ((`PDR_REF_UP_US * 1000 + `PDR_CLK_PERIOD_NS - 1) / `PDR_CLK_PERIOD_NS)
`define PDR_CFG_RESET 16'h0000
`define PDR_CNT_W 20
`endif

// ### pdr_ctrl.sv
// Power-down and reset control classified by the low time of one pin
// What this block does
// - Power-down switches off everything, restores configuration
// - Power-down clears and disables temperature averaging
// - Low for 90 ns or more powers down
// - Pin passes two synchroniser flops before use, so lows under one clock may be missed
// - Digital inputs ignored while powered down
// - Pin high again wakes up in defaults
// - Low under 60 ns resets without power-down
// - Short reset restores configuration, clears averaging
// - After reset pulse the device is normal
// - Pulses 60 to 90 ns reset, may power down
// - Power-on reset clears configuration to zeros
// - Serial interface works 500 us after power-up
// - Averaging enable input, taken with each accepted write, steers averaging
`include "pdr_cfg.svh"
module pdr_ctrl (
   // Clock and power-on reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // Dual-function control pin, active low
   input wire logic i_powerdown_reset_pin_n,
   // Digital inputs from the serial interface
   input wire logic [15:0] i_cfg_wdata,
   input wire logic i_cfg_we,
   input wire logic i_avg_enable,
   // Outputs to the converter core
   output pdr_pkg::pdr_status_s o_status,
   output logic [15:0] o_cfg,
   output logic o_avg_active
);
   import pdr_pkg::*;

   localparam logic [`PDR_CNT_W-1:0] LONG_CYC = `PDR_CNT_W'(`PDR_LONG_CYC);
   localparam logic [`PDR_CNT_W-1:0] IFACE_CYC = `PDR_CNT_W'(`PDR_IFACE_UP_CYC);
   localparam logic [`PDR_CNT_W-1:0] REF_CYC = `PDR_CNT_W'(`PDR_REF_UP_CYC);

   // ****************************************
   // Pin synchroniser
   // ****************************************
   // Lows shorter than one clock may slip between samples; the host never sends them
   logic pin_meta_reg, pin_sync_reg;
   // The pin has no relation to our clock, so two flops precede any use
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         pin_meta_reg <= 1'b1;
         pin_sync_reg <= 1'b1;
      end else begin
         pin_meta_reg <= i_powerdown_reset_pin_n;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // ****************************************
   // Low-time classifier
   // ****************************************
   pdr_state_e state_reg, state_next;
   logic [`PDR_CNT_W-1:0] low_cnt_reg, low_cnt_next;
   logic [`PDR_CNT_W-1:0] up_cnt_reg, up_cnt_next;
   logic rst_pulse_next, rst_pulse_reg;
   logic iface_next, iface_reg, ref_next, ref_reg;

   // Counter restarts on each falling edge and runs while the pin stays low, stopping at the long mark
   always_comb begin
      state_next = state_reg;
      low_cnt_next = low_cnt_reg;
      up_cnt_next = up_cnt_reg;
      rst_pulse_next = 1'b0;
      if (up_cnt_reg != REF_CYC) begin
         up_cnt_next = up_cnt_reg + `PDR_CNT_W'(1);
      end
      unique case (state_reg)
         PDR_ST_NORMAL: begin
            if (!pin_sync_reg) begin
               state_next = PDR_ST_LOW;
               low_cnt_next = `PDR_CNT_W'(1);
               rst_pulse_next = 1'b1;
            end
         end
         PDR_ST_LOW: begin
            if (pin_sync_reg) begin
               state_next = PDR_ST_NORMAL;
            end else if (low_cnt_reg >= LONG_CYC - `PDR_CNT_W'(1)) begin
               // Twelve samples is 96 ns, the first whole cycle count past 90 ns
               // Middle band resolves to power-down only once the long mark passes
               state_next = PDR_ST_DOWN;
            end else begin
               low_cnt_next = low_cnt_reg + `PDR_CNT_W'(1);
            end
         end
         PDR_ST_DOWN: begin
            up_cnt_next = '0;
            if (pin_sync_reg) begin
               state_next = PDR_ST_NORMAL;
            end
         end
      endcase
      // Ready flags follow the next count, so they line up with the counter itself
      iface_next = (up_cnt_next >= IFACE_CYC);
      ref_next = (up_cnt_next == REF_CYC);
   end

   // Register the classifier state and the start-up flags
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= PDR_ST_NORMAL;
         low_cnt_reg <= '0;
         up_cnt_reg <= '0;
         rst_pulse_reg <= 1'b0;
         iface_reg <= 1'b0;
         ref_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         low_cnt_reg <= low_cnt_next;
         up_cnt_reg <= up_cnt_next;
         rst_pulse_reg <= rst_pulse_next;
         iface_reg <= iface_next;
         ref_reg <= ref_next;
      end
   end

   // ****************************************
   // Configuration and averaging state
   // ****************************************
   logic [15:0] cfg_reg, cfg_next;
   logic avg_reg, avg_next;
   logic held;
   assign held = (state_reg != PDR_ST_NORMAL);

   // Writes only land when awake and the interface has had its start-up time
   always_comb begin
      cfg_next = cfg_reg;
      avg_next = avg_reg;
      if (held) begin
         cfg_next = `PDR_CFG_RESET;
         avg_next = 1'b0;
      end else if (i_cfg_we && iface_reg) begin
         cfg_next = i_cfg_wdata;
         avg_next = i_avg_enable;
      end
   end

   // Register configuration and averaging enable
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         cfg_reg <= `PDR_CFG_RESET;
         avg_reg <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
         avg_reg <= avg_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Status levels are flops or decodes of one-hot state flops, so they stay glitch-free
   assign o_cfg = cfg_reg;
   assign o_avg_active = avg_reg;
   assign o_status.powered_down = (state_reg == PDR_ST_DOWN);
   assign o_status.reset_pulse = rst_pulse_reg;
   assign o_status.avg_clear = held;
   assign o_status.iface_ready = iface_reg;
   assign o_status.ref_ready = ref_reg;

   // ****************************************
   // Assertions
   // ****************************************
   // Power-down leaves nothing of the old configuration behind
   a_down_cfg_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
      state_reg == PDR_ST_DOWN |=> cfg_reg == `PDR_CFG_RESET)
      else $error("config not cleared in power-down");
   // Averaging stays off while down
   a_down_avg_off: assert property (@(posedge i_mclk) disable iff (i_rst)
      state_reg == PDR_ST_DOWN |=> !avg_reg)
      else $error("averaging active in power-down");
   // Twelve low samples in a row (8 plus 3 after the first) must end in power-down
   a_long_low_down: assert property (@(posedge i_mclk) disable iff (i_rst)
      $fell(pin_sync_reg) && state_reg == PDR_ST_NORMAL ##1 !pin_sync_reg [*8]
      ##1 !pin_sync_reg [*3]
      |=> state_reg == PDR_ST_DOWN)
      else $error("long low pulse did not power down");
   // A one-sample low never reaches power-down
   a_short_no_down: assert property (@(posedge i_mclk) disable iff (i_rst)
      state_reg == PDR_ST_NORMAL ##1 !pin_sync_reg ##1 pin_sync_reg
      |-> state_reg != PDR_ST_DOWN ##1 state_reg == PDR_ST_NORMAL)
      else $error("short pulse misclassified");
   // Writes while held leave the defaults in place
   a_write_ignored: assert property (@(posedge i_mclk) disable iff (i_rst)
      held && i_cfg_we |=> cfg_reg == `PDR_CFG_RESET)
      else $error("write accepted while held");
   // Wake-up comes back in defaults with the interface timer restarted
   a_wake_default: assert property (@(posedge i_mclk) disable iff (i_rst)
      state_reg == PDR_ST_DOWN && pin_sync_reg |=> state_reg == PDR_ST_NORMAL
      && cfg_reg == `PDR_CFG_RESET && !o_status.iface_ready)
      else $error("wake-up not in defaults");
   // Every fresh low gives one reset pulse and then averaging off
   a_reset_pulse: assert property (@(posedge i_mclk) disable iff (i_rst)
      state_reg == PDR_ST_NORMAL && !pin_sync_reg |=> o_status.reset_pulse
      ##1 !avg_reg)
      else $error("reset pulse missing");
   // Early writes are dropped
   a_iface_gate: assert property (@(posedge i_mclk) disable iff (i_rst)
      !o_status.iface_ready && i_cfg_we && !held |=> $stable(cfg_reg))
      else $error("write before interface ready");
   // The end of a reset pulse returns to normal mode
   a_low_ends_normal: assert property (@(posedge i_mclk) disable iff (i_rst)
      state_reg == PDR_ST_LOW && pin_sync_reg |=> state_reg == PDR_ST_NORMAL)
      else $error("reset pulse did not end in normal mode");
   // Below the long mark a held low keeps measuring instead of powering down
   a_mid_band_waits: assert property (@(posedge i_mclk) disable iff (i_rst)
      state_reg == PDR_ST_LOW && !pin_sync_reg && low_cnt_reg < LONG_CYC - `PDR_CNT_W'(1)
      |=> state_reg == PDR_ST_LOW)
      else $error("low time decided too early");
   // Power-down restarts both start-up timers
   a_wake_restart: assert property (@(posedge i_mclk) disable iff (i_rst)
      state_reg == PDR_ST_DOWN |=> !o_status.iface_ready && !o_status.ref_ready)
      else $error("start-up timers not restarted");
   // A falling pin is acted on whatever else is going on
   a_start_low: assert property (@(posedge i_mclk) disable iff (i_rst)
      $fell(pin_sync_reg) && state_reg == PDR_ST_NORMAL |=> state_reg == PDR_ST_LOW)
      else $error("falling pin not acted on");
endmodule

// ### pdr_host.sv
// Host model that drives the dual-function control pin low for a set time
module pdr_host (
   // Clock
   input wire logic i_mclk,
   // Pulse request and its low time in clock cycles
   input wire logic i_go,
   input wire logic [7:0] i_len,
   // Control pin, active low
   output logic o_pin_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_reg = 8'h00;
   logic pin_reg = 1'b1;
   assign o_pin_n = pin_reg;
   // Widths stay off the 60 to 90 ns band, which gives no sure outcome
   always @(posedge i_mclk) begin
      if (i_go) begin
         cnt_reg <= i_len; // Short width resets, long width powers down
         pin_reg <= 1'b0;
      end else if (cnt_reg > 8'h01) begin
         cnt_reg <= cnt_reg - 8'h01;
      end else begin
         pin_reg <= 1'b1;
      end
   end
endmodule

// ### pdr_pkg.sv
// Types shared by the power-down and reset control block
package pdr_pkg;
   typedef enum logic [2:0] {
      PDR_ST_NORMAL = 3'b001,
      PDR_ST_LOW = 3'b010,
      PDR_ST_DOWN = 3'b100
   } pdr_state_e;
   // Outgoing status toward the converter core
   typedef struct packed {
      logic powered_down;
      logic reset_pulse;
      logic avg_clear;
      logic iface_ready;
      logic ref_ready;
   } pdr_status_s;
endpackage

// ### testbench.sv
// Self-checking bench for the power-down and reset control block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk = 1'b0, i_rst = 1'b1, go = 1'b0, pin_n, we = 1'b0, avg = 1'b0, rp_seen = 1'b0;
   logic [7:0] len = 8'h00;
   logic [15:0] wdata = 16'h0000, o_cfg;
   logic o_avg_active;
   pdr_pkg::pdr_status_s o_status;
   int bad_count = 0, n_compared = 0;
   always #4 i_mclk = ~i_mclk;
   pdr_host pdr_host_inst (.i_mclk(i_mclk), .i_go(go), .i_len(len), .o_pin_n(pin_n));
   pdr_ctrl pdr_ctrl_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_powerdown_reset_pin_n(pin_n),
      .i_cfg_wdata(wdata), .i_cfg_we(we), .i_avg_enable(avg), .o_status(o_status),
      .o_cfg(o_cfg), .o_avg_active(o_avg_active));
   // Remember any start-of-pulse indication; a new pulse request clears it
   always @(posedge i_mclk) begin
      if (go) rp_seen <= 1'b0;
      else if (o_status.reset_pulse === 1'b1) rp_seen <= 1'b1;
   end
   // Configuration expected after a write: the word when taken, defaults otherwise
   function automatic logic [15:0] exp_cfg(input logic [15:0] d, input logic taken);
      return taken ? d : 16'h0000;
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One write strobe, then two more edges for the answer to land
   task automatic wr(input logic [15:0] d, input logic a);
      @(posedge i_mclk);
      wdata <= d;
      avg <= a;
      we <= 1'b1;
      @(posedge i_mclk);
      we <= 1'b0;
      repeat (2) @(posedge i_mclk);
   endtask
   task automatic pulse(input logic [7:0] n);
      @(posedge i_mclk);
      go <= 1'b1;
      len <= n;
      @(posedge i_mclk);
      go <= 1'b0;
   endtask
   // Longest path is one interface start-up of 62500 cycles plus a little
   initial begin
      #(70000 * 8);
      bad_count++;
      conclude();
   end
   initial begin
      logic [15:0] d;
      logic a;
      int k;
      void'($urandom(32823));
      repeat (4) @(posedge i_mclk);
      i_rst <= 1'b0;
      @(posedge i_mclk);
      chk(o_cfg, 16'h0000);
      chk(o_status.iface_ready, 1'b0);
      // Writes before the interface is up are dropped
      wr(16'h5a5a, 1'b1);
      chk(o_cfg, exp_cfg(16'h5a5a, 1'b0));
      for (k = 0; k < 66000 && o_status.iface_ready !== 1'b1; k++) @(posedge i_mclk);
      chk(o_status.iface_ready, 1'b1);
      chk(o_status.ref_ready, 1'b0);
      $display("test power-on done");
      for (k = 0; k < 6; k++) begin
         d = (k == 0) ? 16'hffff : 16'($urandom());
         a = 1'($urandom());
         wr(d, a);
         chk(o_cfg, exp_cfg(d, 1'b1));
         chk(o_avg_active, a);
         // Short low pulse of 1 to 7 cycles, under 60 ns
         pulse(8'($urandom_range(1, 7)));
         repeat (14) @(posedge i_mclk);
         chk(rp_seen, 1'b1);
         chk(o_status.powered_down, 1'b0);
         chk(o_cfg, 16'h0000);
         chk(o_avg_active, 1'b0);
         chk(o_status.iface_ready, 1'b1);
      end
      $display("test short reset done");
      wr(16'h0f0f, 1'b1);
      pulse(8'h28);
      repeat (20) @(posedge i_mclk);
      chk(o_status.powered_down, 1'b1);
      chk(o_cfg, 16'h0000);
      chk(o_status.avg_clear, 1'b1);
      chk(o_avg_active, 1'b0);
      wr(16'h1234, 1'b1);
      chk(o_cfg, 16'h0000);
      chk(o_status.ref_ready, 1'b0);
      repeat (30) @(posedge i_mclk);
      chk(o_status.powered_down, 1'b0);
      chk(o_cfg, 16'h0000);
      chk(o_status.iface_ready, 1'b0);
      $display("test power-down done");
      conclude();
   end
endmodule
